// File: design/spram_core.sv
`timescale 1ns/100ps
// ==========================================================================
// single-port embedded ram with apb image loader and control
module spram_core
  import spram_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter spram_dtype_type DTYPE = SPRAM_SINT,
  parameter int INT_BITS = 8,
  parameter int FRAC_BITS = 0,
  parameter spram_blk_type BLK = SPRAM_BLK_AUTO,
  parameter spram_init_type INIT = SPRAM_INIT_BLANK,
  parameter int INIT_LEN = 0,
  parameter logic [DEPTH*(INT_BITS+FRAC_BITS)-1:0] INIT_ARRAY = '0,
  parameter bit REG_OUT = 1'h1,
  parameter bit USE_ENA = 1'h1,
  parameter int PHASE_LEN = 1,
  parameter logic [SPRAM_PHASE_MAX-1:0] PHASE_PAT = 16'h0001
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  // shared port
  input wire logic [INT_BITS+FRAC_BITS-1:0] ram_wdata,
  input wire logic [((DEPTH > 1) ? $clog2(DEPTH) : 1)-1:0] ram_addr,
  input wire logic ram_wren,
  input wire logic ram_ena,
  output logic [INT_BITS+FRAC_BITS-1:0] ram_rdata,
  output logic ram_rsign,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int W = INT_BITS + FRAC_BITS;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int PW = ((W + SPRAM_BYTE_W - 1) / SPRAM_BYTE_W) * SPRAM_BYTE_W;
  localparam logic [63:0] PW_ONES = (64'h1 << PW) - 64'h1;
  localparam logic [63:0] W_ONES = (64'h1 << W) - 64'h1;
  localparam logic [31:0] PAD_MASK = 32'(PW_ONES ^ W_ONES);
  localparam bit IS_SIGNED = (DTYPE == SPRAM_SINT) || (DTYPE == SPRAM_SFRAC);
  localparam bit IS_LARGE = (BLK == SPRAM_BLK_LARGE);
  localparam logic [32:0] DEPTH_EXT = 33'(DEPTH);

  // ==========================================================================
  // elaboration checks
  if (DEPTH < 1) begin : g_bad_depth
    $error("spram_core: depth must be at least one");
  end
  if (INT_BITS < 0 || FRAC_BITS < 0 || W < 1 || W > SPRAM_BUS_W) begin : g_bad_width
    $error("spram_core: word width out of range");
  end
  if (FRAC_BITS != 0 && DTYPE != SPRAM_SFRAC) begin : g_bad_frac
    $error("spram_core: fraction bits only for signed fractional");
  end
  if (INIT_LEN < 0 || INIT_LEN > DEPTH) begin : g_bad_init
    $error("spram_core: initial array longer than depth");
  end

  // ==========================================================================
  // storage and its configured starting image
  typedef logic [W-1:0] spram_mem_type [DEPTH];

  // large blocks power up unknown, others zero or the array words
  function automatic spram_mem_type init_image();
    spram_mem_type img;
    for (int i = 0; i < DEPTH; i++) begin
      if (IS_LARGE) begin
        img[i] = 'x;
      end else if (INIT == SPRAM_INIT_ARRAY && i < INIT_LEN) begin
        img[i] = INIT_ARRAY[i*W +: W];
      end else begin
        img[i] = '0;
      end
    end
    return img;
  endfunction

  spram_mem_type mem = init_image();

  logic run_r;
  logic ce_eff;
  logic phase_en;
  logic [SPRAM_PIDX_W-1:0] phase_idx;
  logic restart_p;
  logic [W-1:0] wdata_r;
  logic [AW-1:0] addr_r;
  logic wren_r;
  logic rng_ok;
  logic [W-1:0] rd_word;
  logic [W-1:0] q_mem_r;
  logic [W-1:0] q_out_r;
  logic port_wr;
  logic [SPRAM_HALF_W-1:0] ext_r;
  logic [SPRAM_HALF_W-1:0] ofs_r;
  logic [SPRAM_BUS_W-1:0] ld_addr;
  logic ld_in_range;
  logic pad_ok;
  logic apb_setup;
  logic apb_fire;
  logic ld_fire;
  logic ctrl_wr;
  logic status_wr;
  logic [31:0] pad_bits;
  spram_status_type status;
  logic range_err_r;
  logic pad_err_r;
  logic [31:0] rd_mux;
  logic map_hit;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // ==========================================================================
  // phase selection
  spram_phase #(
    .PHASE_LEN(PHASE_LEN),
    .PHASE_PAT(PHASE_PAT)
  ) u_phase (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .restart(restart_p),
    .phase_en(phase_en),
    .phase_idx(phase_idx)
  );

  // enable folds port enable, phase and the software run bit
  assign ce_eff = (USE_ENA ? ram_ena : 1'h1) & phase_en & run_r;

  // ==========================================================================
  // input register stage, held while disabled
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wdata_r <= '0;
      addr_r <= '0;
      wren_r <= 1'h0;
    end else if (ce_eff) begin
      wdata_r <= ram_wdata;
      addr_r <= ram_addr;
      wren_r <= ram_wren;
    end
  end

  // unsigned compare; a non power of two depth leaves holes
  assign rng_ok = 33'(addr_r) < DEPTH_EXT;
  assign rd_word = mem[addr_r];
  assign port_wr = ce_eff & wren_r & rng_ok;

  // ==========================================================================
  // memory stage: port write first, loader only in a free cycle
  always_ff @(posedge clk_sys) begin
    if (port_wr) begin
      mem[addr_r] <= wdata_r;
    end else if (ld_fire && ld_in_range) begin
      mem[ld_addr[AW-1:0]] <= pwdata[W-1:0];
    end
  end

  // read stage returns the word before the write lands, or unknown on a large block write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_mem_r <= '0;
    end else if (ce_eff) begin
      if (!rng_ok) begin
        q_mem_r <= '0;
      end else if (IS_LARGE && wren_r) begin
        q_mem_r <= 'x;
      end else begin
        q_mem_r <= rd_word;
      end
    end
  end

  // output register ignores the enable so it always drains
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_out_r <= '0;
    end else begin
      q_out_r <= q_mem_r;
    end
  end

  assign ram_rdata = REG_OUT ? q_out_r : q_mem_r;
  assign ram_rsign = IS_SIGNED ? ram_rdata[W-1] : 1'h0;

  // ==========================================================================
  // apb decode
  assign apb_setup = psel & ~penable;
  assign map_hit = (paddr == SPRAM_OFS_CTRL) || (paddr == SPRAM_OFS_STATUS) ||
                   (paddr == SPRAM_OFS_LOAD_EXT) || (paddr == SPRAM_OFS_LOAD_OFS) ||
                   (paddr == SPRAM_OFS_LOAD_DATA);
  // a loader write waits while the port owns the memory this cycle
  assign pready = ~(pwrite && paddr == SPRAM_OFS_LOAD_DATA && port_wr);
  assign apb_fire = psel & penable & pready;
  assign ctrl_wr = apb_fire & pwrite & (paddr == SPRAM_OFS_CTRL);
  assign status_wr = apb_fire & pwrite & (paddr == SPRAM_OFS_STATUS);
  assign ld_fire = apb_fire & pwrite & (paddr == SPRAM_OFS_LOAD_DATA);
  assign restart_p = ctrl_wr & pwdata[SPRAM_CTRL_RESTART_BIT];

  // control: run bit gates the input and read stages
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_r <= SPRAM_RUN_RESET;
    end else if (ctrl_wr) begin
      run_r <= pwdata[SPRAM_CTRL_RUN_BIT];
    end
  end

  // ==========================================================================
  // image loader: extended upper half plus auto-incrementing offset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_r <= SPRAM_LOAD_RESET;
    end else if (apb_fire && pwrite && paddr == SPRAM_OFS_LOAD_EXT) begin
      ext_r <= pwdata[SPRAM_HALF_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ofs_r <= SPRAM_LOAD_RESET;
    end else if (apb_fire && pwrite && paddr == SPRAM_OFS_LOAD_OFS) begin
      ofs_r <= pwdata[SPRAM_HALF_W-1:0];
    end else if (ld_fire) begin
      ofs_r <= ofs_r + 16'h0001;
    end
  end

  assign ld_addr = {ext_r, ofs_r};
  assign ld_in_range = 33'(ld_addr) < DEPTH_EXT;
  // pad above a non-byte word: all zero, or all ones on a negative word
  assign pad_bits = pwdata & PAD_MASK;
  assign pad_ok = (pad_bits == '0) || (pad_bits == PAD_MASK && pwdata[W-1]);

  // sticky flags, write one clears, a new event beats the clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      range_err_r <= 1'h0;
    end else if (ld_fire && !ld_in_range) begin
      range_err_r <= 1'h1;
    end else if (status_wr && pwdata[SPRAM_STAT_RANGE_BIT]) begin
      range_err_r <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pad_err_r <= 1'h0;
    end else if (ld_fire && !pad_ok) begin
      pad_err_r <= 1'h1;
    end else if (status_wr && pwdata[SPRAM_STAT_PAD_BIT]) begin
      pad_err_r <= 1'h0;
    end
  end

  assign status = '{pad_err: pad_err_r, range_err: range_err_r, phase_idx: phase_idx};

  // ==========================================================================
  // read mux, captured in the setup cycle so prdata comes from flops
  always_comb begin
    rd_mux = '0;
    if (paddr == SPRAM_OFS_CTRL) begin
      rd_mux[SPRAM_CTRL_RUN_BIT] = run_r;
    end else if (paddr == SPRAM_OFS_STATUS) begin
      rd_mux[SPRAM_PIDX_W-1:0] = status.phase_idx;
      rd_mux[SPRAM_STAT_RANGE_BIT] = status.range_err;
      rd_mux[SPRAM_STAT_PAD_BIT] = status.pad_err;
    end else if (paddr == SPRAM_OFS_LOAD_EXT) begin
      rd_mux[SPRAM_HALF_W-1:0] = ext_r;
    end else if (paddr == SPRAM_OFS_LOAD_OFS) begin
      rd_mux[SPRAM_HALF_W-1:0] = ofs_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= '0;
      pslverr_r <= 1'h0;
    end else if (apb_setup) begin
      prdata_r <= rd_mux;
      pslverr_r <= ~map_hit;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_IN_CAPTURE: assert property (
    ce_eff |=> addr_r == $past(ram_addr) && wren_r == $past(ram_wren))
    else $error("input stage missed an enabled capture");
  AST_GATED_HOLD: assert property (
    !ce_eff |=> $stable(addr_r) && $stable(wdata_r) && $stable(q_mem_r))
    else $error("disabled stage changed");
  AST_OUT_UNGATED: assert property (
    !ce_eff ##1 !ce_eff |-> q_out_r == $past(q_mem_r))
    else $error("output register stalled by enable");
  AST_REG_LATENCY: assert property (
    REG_OUT |-> ##1 ram_rdata == $past(q_mem_r))
    else $error("registered output not one cycle behind read stage");
  AST_NO_ENA: assert property (
    (!USE_ENA && phase_en && run_r) |-> ce_eff)
    else $error("block idle although enable port absent");
  AST_WRITE_STORE: assert property (
    port_wr |=> mem[$past(addr_r)] == $past(wdata_r))
    else $error("enabled write not stored");
  AST_OLD_DATA: assert property (
    (!IS_LARGE && port_wr) |=> q_mem_r == $past(rd_word))
    else $error("write did not return old contents");
  AST_OOR_READ: assert property (
    (ce_eff && !rng_ok) |=> q_mem_r == '0)
    else $error("read beyond depth not zero");
  AST_SIGN: assert property (
    (IS_SIGNED && REG_OUT) |=> ram_rsign == $past(q_mem_r[W-1]))
    else $error("sign bit not msb");
  AST_LOAD_RANGE: assert property (
    (ld_fire && !ld_in_range) |=> range_err_r ##1 (range_err_r || $past(status_wr)))
    else $error("out of range load not flagged");
  AST_PAD: assert property (
    (ld_fire && !pad_ok) |=> pad_err_r)
    else $error("bad padding not flagged");
  AST_LOAD_STORE: assert property (
    (ld_fire && ld_in_range && !port_wr) |=> mem[$past(ld_addr[AW-1:0])] == $past(pwdata[W-1:0]))
    else $error("loader word not stored");

  CV_PORT_WRITE: cover property (port_wr ##1 ce_eff && !wren_r);
  CV_GATED: cover property (!ce_eff [*2] ##1 ce_eff);
  CV_LOAD: cover property (ld_fire && ld_in_range);
  CV_LOAD_STALL: cover property (psel && penable && !pready);

endmodule

// File: design/spram_pkg.sv
// ==========================================================================
// shared constants and types of the single-port ram
package spram_pkg;

  // register byte offsets on the apb side
  localparam logic [7:0] SPRAM_OFS_CTRL = 8'h00;
  localparam logic [7:0] SPRAM_OFS_STATUS = 8'h04;
  localparam logic [7:0] SPRAM_OFS_LOAD_EXT = 8'h08;
  localparam logic [7:0] SPRAM_OFS_LOAD_OFS = 8'h0c;
  localparam logic [7:0] SPRAM_OFS_LOAD_DATA = 8'h10;

  // field positions and reset values
  localparam int SPRAM_CTRL_RUN_BIT = 0;
  localparam int SPRAM_CTRL_RESTART_BIT = 1;
  localparam int SPRAM_STAT_RANGE_BIT = 8;
  localparam int SPRAM_STAT_PAD_BIT = 9;
  localparam logic SPRAM_RUN_RESET = 1'h1;
  localparam logic [15:0] SPRAM_LOAD_RESET = 16'h0000;

  // image format: bytes, 16-bit record offset, 16-bit extended upper address
  localparam int SPRAM_BYTE_W = 8;
  localparam int SPRAM_HALF_W = 16;
  localparam int SPRAM_BUS_W = 32;

  // phase pattern limits
  localparam int SPRAM_PHASE_MAX = 16;
  localparam int SPRAM_PIDX_W = 4;

  typedef enum {SPRAM_INFERRED, SPRAM_SINT, SPRAM_UINT, SPRAM_SFRAC} spram_dtype_type;
  typedef enum {SPRAM_INIT_BLANK, SPRAM_INIT_HEX, SPRAM_INIT_ARRAY} spram_init_type;
  typedef enum {SPRAM_BLK_AUTO, SPRAM_BLK_SMALL, SPRAM_BLK_LARGE} spram_blk_type;

  // sticky flags and phase index carried as one packed group
  typedef struct packed {
    logic pad_err;
    logic range_err;
    logic [SPRAM_PIDX_W-1:0] phase_idx;
  } spram_status_type;

endpackage

// File: design/spram_phase.sv
`timescale 1ns/100ps
// ==========================================================================
// phase selector: walks the pattern, first character is phase one
module spram_phase
  import spram_pkg::*;
#(
  parameter int PHASE_LEN = 1,
  parameter logic [SPRAM_PHASE_MAX-1:0] PHASE_PAT = 16'h0001
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic restart,
  output logic phase_en,
  output logic [SPRAM_PIDX_W-1:0] phase_idx
);

  localparam logic [SPRAM_PIDX_W-1:0] LAST = SPRAM_PIDX_W'(PHASE_LEN - 1);
  localparam logic [SPRAM_PHASE_MAX-1:0] USED = SPRAM_PHASE_MAX'((32'h1 << PHASE_LEN) - 32'h1);

  // ==========================================================================
  // elaboration checks
  if (PHASE_LEN < 1 || PHASE_LEN > SPRAM_PHASE_MAX) begin : g_bad_len
    $error("spram_phase: pattern length out of range");
  end
  if ((PHASE_PAT & USED) == '0) begin : g_bad_pat
    $error("spram_phase: pattern never enables the block");
  end

  logic [SPRAM_PIDX_W-1:0] idx_r;
  logic [SPRAM_PIDX_W-1:0] sel;

  // ==========================================================================
  // phase counter, restart forces phase one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idx_r <= '0;
    end else if (restart || idx_r == LAST) begin
      idx_r <= '0;
    end else begin
      idx_r <= idx_r + 4'h1;
    end
  end

  // msb of the used pattern is phase one
  assign sel = LAST - idx_r;
  assign phase_en = PHASE_PAT[sel];
  assign phase_idx = idx_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_PHASE_WRAP: assert property (
    (idx_r == LAST && !restart) |=> idx_r == '0)
    else $error("phase counter did not wrap");
  AST_PHASE_BOUND: assert property (
    idx_r <= LAST)
    else $error("phase counter beyond pattern");
  CV_PHASE_WRAP: cover property (idx_r == LAST ##1 idx_r == '0);

endmodule

// File: verif/spram_drv.sv
`timescale 1ns/100ps
// ==========================================================================
// datapath side of the shared port: one access per call
module spram_drv #(
  parameter int W = 8,
  parameter int AW = 8
) (
  input wire logic clk_sys,
  output logic [W-1:0] ram_wdata,
  output logic [AW-1:0] ram_addr,
  output logic ram_wren,
  output logic ram_ena,
  input wire logic [W-1:0] ram_rdata
);
  // idle state: reading, enable up
  initial begin
    ram_wdata = '0;
    ram_addr = '0;
    ram_wren = 1'b0;
    ram_ena = 1'b1;
  end
  // en low models a stalled source; the request is then not taken
  task automatic access(input logic we, input logic [AW-1:0] a, input logic [W-1:0] d,
                        input logic en, output logic [W-1:0] q);
    @(posedge clk_sys);
    ram_addr <= a;
    ram_wren <= we;
    ram_wdata <= d;
    ram_ena <= en;
    @(posedge clk_sys);
    ram_wren <= 1'b0;
    ram_ena <= 1'b1;
    ram_wdata <= ~d; // released data must not look like a held copy
    // stage one, memory, output register
    repeat (2) @(posedge clk_sys);
    #1;
    q = ram_rdata;
  endtask
endmodule

// File: verif/spram_core_bench.sv
`timescale 1ns/100ps
// ==========================================================================
// self-checking bench of the single-port ram
module spram_core_bench;
  import spram_pkg::*;
  // depth below the address range so that out-of-range words exist
  localparam int DEPTH = 200;
  localparam int W = 8;
  localparam int AW = 8;
  typedef struct packed {
    logic [AW-1:0] a;
    logic [W-1:0] d;
    logic [W-1:0] old;
  } spram_row_type;
  localparam spram_row_type ROWS [5] = '{'{8'h00, 8'h5a, 8'h00}, '{8'hc7, 8'h81, 8'h00},
    '{8'h7f, 8'h80, 8'h00}, '{8'h7f, 8'h3c, 8'h80}, '{8'h01, 8'hff, 8'h00}};
  localparam logic [7:0] ROFS [5] = '{SPRAM_OFS_CTRL, SPRAM_OFS_STATUS, SPRAM_OFS_LOAD_EXT,
    SPRAM_OFS_LOAD_OFS, SPRAM_OFS_LOAD_DATA};
  localparam logic [31:0] RRST [5] = '{32'h00000001, 32'h0, 32'h0, 32'h0, 32'h0};
  logic clk_sys;
  logic rst_b;
  logic [W-1:0] ram_wdata;
  logic [AW-1:0] ram_addr;
  logic ram_wren;
  logic ram_ena;
  logic [W-1:0] ram_rdata;
  logic ram_rsign;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int errors;
  int total_checks;
  localparam int W_B = 6;
  logic [W_B-1:0] wd_b;
  logic [1:0] ad_b;
  logic we_b;
  logic en_b;
  logic [W_B-1:0] rdata_b;
  logic rsign_b;
  logic [31:0] prdata_b;
  logic [31:0] rd_b;

  spram_core #(.DEPTH(DEPTH)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ram_wdata(ram_wdata),
    .ram_addr(ram_addr), .ram_wren(ram_wren), .ram_ena(ram_ena), .ram_rdata(ram_rdata),
    .ram_rsign(ram_rsign), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  spram_drv #(.W(W), .AW(AW)) u_drv (.clk_sys(clk_sys), .ram_wdata(ram_wdata),
    .ram_addr(ram_addr), .ram_wren(ram_wren), .ram_ena(ram_ena), .ram_rdata(ram_rdata));
  // second build: 6-bit words, unregistered, no enable port, phase "10", short array image;
  // word 2 of the array lies past its length and must still start zero
  spram_core #(.DEPTH(4), .INT_BITS(W_B), .INIT(SPRAM_INIT_ARRAY), .INIT_LEN(2),
    .INIT_ARRAY(24'h03f2a5), .REG_OUT(1'h0), .USE_ENA(1'h0), .PHASE_LEN(2),
    .PHASE_PAT(16'h0002)) u_dut_b (.clk_sys(clk_sys), .rst_b(rst_b), .ram_wdata(wd_b),
    .ram_addr(ad_b), .ram_wren(we_b), .ram_ena(en_b), .ram_rdata(rdata_b),
    .ram_rsign(rsign_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_b), .pready(), .pslverr());

  // ==========================================================================
  // clock and report
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_data(input string n, input logic [W-1:0] e, input logic [W-1:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_flag(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  // apb master; pready, read data and error are all taken at the completing edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      give_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      rd_b = prdata_b;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // second build: hold one address until the phase-gated pipeline has settled
  task automatic peek_b(input logic [1:0] a, output logic [W_B-1:0] q);
    @(posedge clk_sys);
    ad_b <= a;
    repeat (6) @(posedge clk_sys);
    #1;
    q = rdata_b;
  endtask
  // hang guard
  initial begin
    #200000;
    errors++;
    give_verdict();
  end

  // ==========================================================================
  // main sequence
  initial begin
    logic [W-1:0] q;
    logic [31:0] v;
    logic e;
    int i;
    logic [W_B-1:0] qb;
    logic [W_B-1:0] m2;
    errors = 0;
    total_checks = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wd_b = '0;
    ad_b = 2'h0;
    we_b = 1'b0;
    en_b = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk_data("rdata in reset", '0, ram_rdata);
    chk_flag("pready idle", 1'b1, pready);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    for (i = 0; i < 5; i++) begin
      apb(1'b0, ROFS[i], 32'h0, v, e);
      chk_reg("register reset", RRST[i], v);
    end
    // rows: first writes return blank contents, a rewrite returns the old word
    for (i = 0; i < 5; i++) begin
      u_drv.access(1'b1, ROWS[i].a, ROWS[i].d, 1'b1, q);
      chk_data("old word on write", ROWS[i].old, q);
      u_drv.access(1'b0, ROWS[i].a, '0, 1'b1, q);
      chk_data("read back", ROWS[i].d, q);
      chk_flag("sign bit", ROWS[i].d[W-1], ram_rsign);
    end
    // beyond the last word: write dropped, read zero
    u_drv.access(1'b1, 8'hfa, 8'h77, 1'b1, q);
    u_drv.access(1'b0, 8'hfa, '0, 1'b1, q);
    chk_data("out of range read", '0, q);
    // stalled source: enable low, nothing stored
    u_drv.access(1'b1, 8'h00, 8'h11, 1'b0, q);
    u_drv.access(1'b0, 8'h00, '0, 1'b1, q);
    chk_data("disabled write", 8'h5a, q);
    // frozen pipeline through the run bit
    apb(1'b1, SPRAM_OFS_CTRL, 32'h0, v, e);
    u_drv.access(1'b1, 8'h00, 8'h22, 1'b1, q);
    apb(1'b1, SPRAM_OFS_CTRL, 32'h1, v, e);
    u_drv.access(1'b0, 8'h00, '0, 1'b1, q);
    chk_data("write while frozen", 8'h5a, q);
    // unmapped place
    apb(1'b0, 8'h20, 32'h0, v, e);
    chk_flag("unmapped error", 1'b1, e);
    chk_reg("unmapped read", 32'h0, v);
    // image loader, back-to-back words and offset advance
    apb(1'b1, SPRAM_OFS_LOAD_OFS, 32'h5, v, e);
    apb(1'b1, SPRAM_OFS_LOAD_DATA, 32'h33, v, e);
    apb(1'b1, SPRAM_OFS_LOAD_DATA, 32'hc4, v, e);
    apb(1'b0, SPRAM_OFS_LOAD_OFS, 32'h0, v, e);
    chk_reg("offset advance", 32'h7, v);
    u_drv.access(1'b0, 8'h05, '0, 1'b1, q);
    chk_data("loaded word", 8'h33, q);
    u_drv.access(1'b0, 8'h06, '0, 1'b1, q);
    chk_data("loaded word", 8'hc4, q);
    // upper address takes part: must not alias onto word 3
    apb(1'b1, SPRAM_OFS_LOAD_EXT, 32'h1, v, e);
    apb(1'b1, SPRAM_OFS_LOAD_OFS, 32'h3, v, e);
    apb(1'b1, SPRAM_OFS_LOAD_DATA, 32'h11, v, e);
    u_drv.access(1'b0, 8'h03, '0, 1'b1, q);
    chk_data("extended address", '0, q);
    apb(1'b0, SPRAM_OFS_STATUS, 32'h0, v, e);
    chk_flag("range flag", 1'b1, v[SPRAM_STAT_RANGE_BIT]);
    chk_flag("odd width pad flag", 1'b1, rd_b[SPRAM_STAT_PAD_BIT]);
    apb(1'b1, SPRAM_OFS_STATUS, 32'h100, v, e);
    apb(1'b0, SPRAM_OFS_STATUS, 32'h0, v, e);
    chk_reg("status cleared", 32'h0, v);
    chk_flag("odd width pad sticky", 1'b1, rd_b[SPRAM_STAT_PAD_BIT]);
    chk_flag("odd width range cleared", 1'b0, rd_b[SPRAM_STAT_RANGE_BIT]);
    // second build: array words, zero past the array end, sign of a negative word
    peek_b(2'h0, qb);
    chk_data("array word 0", 8'h25, {2'h0, qb});
    chk_flag("array sign", 1'b1, rsign_b);
    peek_b(2'h1, qb);
    chk_data("array word 1", 8'h0a, {2'h0, qb});
    peek_b(2'h2, qb);
    chk_data("past array end", 8'h00, {2'h0, qb});
    // phase "10" with the enable pin low: of two one-cycle writes on adjacent
    // edges exactly one is taken, whatever the phase alignment
    @(posedge clk_sys);
    ad_b <= 2'h2;
    we_b <= 1'b1;
    wd_b <= 6'h15;
    @(posedge clk_sys);
    ad_b <= 2'h3;
    @(posedge clk_sys);
    we_b <= 1'b0;
    peek_b(2'h2, m2);
    peek_b(2'h3, qb);
    chk_data("phase gated write", 8'h15, {2'h0, m2 | qb});
    chk_flag("one write taken", 1'b1, (m2 == 6'h00) ^ (qb == 6'h00));
    // second reset: output cleared, contents kept
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_data("rdata in reset", '0, ram_rdata);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    u_drv.access(1'b0, 8'h05, '0, 1'b1, q);
    chk_data("kept over reset", 8'h33, q);
    give_verdict();
  end
endmodule
